// [design/scp_parser.sv]
// command-mode interpreter: decodes controller commands, keeps live and saved
// settings, answers each command, and gates the measuring stream.
// assumes a command arrives as one cycle of code plus up to three user words.
`timescale 1ns/100ps
module scp_parser #(
    parameter int ZW             = 16,
    parameter int PAUSE_STEP_CYC = scp_pkg::PAUSE_STEP_CYC
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset_n,
    // command from the controller
    input  wire logic          cmd_valid,
    input  wire logic [15:0]   cmd_code,
    input  wire logic [1:0]    cmd_words,
    input  wire logic [15:0]   cmd_word0,
    input  wire logic [15:0]   cmd_word1,
    input  wire logic [15:0]   cmd_word2,
    // answer to the controller
    output logic               rsp_valid,
    output logic [15:0]        rsp_code,
    output logic               rsp_has_word,
    output logic [15:0]        rsp_word,
    // device events
    input  wire logic          restart,
    input  wire logic          factory_reset,
    // live settings
    output logic               command_mode,
    output logic               measuring,
    output logic               cascade_out_active,
    output logic               laser_on_flag,
    output logic [3:0]         active_task,
    output logic [15:0]        scan_number,
    output logic               x_suppress_flag,
    output logic               x_output_enable,
    output logic [3:0]         pause_steps,
    output logic [19:0]        pause_cycles,
    output logic               median_enable_flag,
    // saved settings, kept over a restart
    output logic [3:0]         saved_task,
    output logic               saved_x_suppress,
    output logic [3:0]         saved_pause,
    output logic               saved_median,
    output logic               save_strobe,
    // z stream through the median filter
    input  wire logic          z_in_valid,
    input  wire logic [ZW-1:0] z_in,
    output logic               z_out_valid,
    output logic [ZW-1:0]      z_out
);
    scp_pkg::scp_mode_t mode_q;
    scp_pkg::scp_mode_t mode_d;

    logic          laser_q;
    logic [3:0]    task_q;
    logic [15:0]   scan_q;
    logic          xsup_q;
    logic [3:0]    pause_q;
    logic          med_q;
    logic [3:0]    sv_task_q;
    logic          sv_xsup_q;
    logic [3:0]    sv_pause_q;
    logic          sv_med_q;
    logic          save_q;
    logic [19:0]   pcyc_q;
    logic          rv_q;
    logic [15:0]   rc_q;
    logic          rh_q;
    logic [15:0]   rw_q;
    logic          zv_q;
    logic [ZW-1:0] zo_q;

    scp_zf_if #(.ZW(ZW)) zf ();

    // decode
    wire in_cmd    = (mode_q == scp_pkg::MODE_COMMAND);
    wire is_enter  = (cmd_code == scp_pkg::CMD_ENTER)    && (cmd_words == scp_pkg::NW_MODE);
    wire is_exit   = (cmd_code == scp_pkg::CMD_EXIT)     && (cmd_words == scp_pkg::NW_MODE);
    wire is_laser  = (cmd_code == scp_pkg::CMD_LASER)    && (cmd_words == scp_pkg::NW_LASER);
    wire is_stask  = (cmd_code == scp_pkg::CMD_SET_TASK) && (cmd_words == scp_pkg::NW_SET_TASK);
    wire is_gtask  = (cmd_code == scp_pkg::CMD_GET_TASK) && (cmd_words == scp_pkg::NW_GET_TASK);
    wire is_scan   = (cmd_code == scp_pkg::CMD_SET_SCAN) && (cmd_words == scp_pkg::NW_SET_SCAN);
    wire is_suser  = (cmd_code == scp_pkg::CMD_SET_USER) && (cmd_words == scp_pkg::NW_SET_USER);
    wire is_guser  = (cmd_code == scp_pkg::CMD_GET_USER) && (cmd_words == scp_pkg::NW_GET_USER);

    // fields
    wire        flag_w0   = cmd_word0[scp_pkg::FLAG_BIT];
    wire        flag_w1   = cmd_word1[scp_pkg::FLAG_BIT];
    wire        flag_w2   = cmd_word2[scp_pkg::FLAG_BIT];
    wire [3:0]  nib_w0    = cmd_word0[scp_pkg::NIBBLE_MSB:0];
    wire [3:0]  nib_w2    = cmd_word2[scp_pkg::NIBBLE_MSB:0];
    wire        pid_x     = (cmd_word1 == scp_pkg::PID_X_OUTPUT);
    wire        pid_pause = (cmd_word1 == scp_pkg::PID_PAUSE);
    wire        pid_med   = (cmd_word1 == scp_pkg::PID_MEDIAN);
    wire        gid_x     = (cmd_word0 == scp_pkg::PID_X_OUTPUT);
    wire        gid_pause = (cmd_word0 == scp_pkg::PID_PAUSE);
    wire        gid_med   = (cmd_word0 == scp_pkg::PID_MEDIAN);
    wire        pause_ok  = (nib_w2 <= scp_pkg::PAUSE_MAX);
    wire        suser_ok  = pid_x || pid_med || (pid_pause && pause_ok);
    wire        guser_ok  = gid_x || gid_pause || gid_med;

    // task nibble spans all 16 values, so only the word count can reject it
    wire do_enter  = cmd_valid && is_enter && !in_cmd;
    wire do_exit   = cmd_valid && is_exit && in_cmd;
    wire do_laser  = cmd_valid && in_cmd && is_laser;
    wire do_stask  = cmd_valid && in_cmd && is_stask;
    wire do_gtask  = cmd_valid && in_cmd && is_gtask;
    wire do_scan   = cmd_valid && in_cmd && is_scan;
    wire do_suser  = cmd_valid && in_cmd && is_suser && suser_ok;
    wire do_guser  = cmd_valid && in_cmd && is_guser && guser_ok;
    wire do_any    = do_enter || do_exit || do_laser || do_stask || do_gtask
                   || do_scan || do_suser || do_guser;

    wire set_x     = do_suser && pid_x;
    wire set_pause = do_suser && pid_pause;
    wire set_med   = do_suser && pid_med;
    wire persist   = (do_stask && flag_w1) || (do_suser && flag_w0);

    // answer selection
    wire [15:0] guser_val = gid_x     ? {15'h0000, xsup_q}
                          : gid_pause ? {12'h000, pause_q}
                          :             {15'h0000, med_q};
    wire [15:0] ans_code  = !do_any  ? scp_pkg::RSP_NAK
                          : do_gtask ? scp_pkg::RSP_TASK
                          : do_guser ? scp_pkg::RSP_USER
                          :            scp_pkg::RSP_ACK;
    wire [15:0] ans_word  = do_gtask ? {12'h000, task_q} : do_guser ? guser_val : 16'h0000;
    wire        ans_has   = do_gtask || do_guser;

    wire [19:0] pcyc_next = 20'((pause_q + 5'h01) * PAUSE_STEP_CYC);

    always_comb begin
        mode_d = mode_q;
        if (do_enter) begin
            mode_d = scp_pkg::MODE_COMMAND;
        end else if (do_exit) begin
            mode_d = scp_pkg::MODE_MEASURE;
        end
    end

    // mode and answer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= scp_pkg::MODE_MEASURE;
            rv_q   <= 1'b0;
            rc_q   <= 16'h0000;
            rh_q   <= 1'b0;
            rw_q   <= 16'h0000;
            pcyc_q <= 20'h00000;
        end else begin
            mode_q <= mode_d;
            rv_q   <= cmd_valid;
            pcyc_q <= pcyc_next;
            if (cmd_valid) begin
                rc_q <= ans_code;
                rh_q <= ans_has;
                rw_q <= ans_word;
            end
        end
    end

    // live settings; one global copy serves every inspection task
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            laser_q <= scp_pkg::RST_LASER;
            task_q  <= scp_pkg::RST_TASK;
            scan_q  <= scp_pkg::RST_SCAN;
            xsup_q  <= scp_pkg::RST_XSUP;
            pause_q <= scp_pkg::RST_PAUSE;
            med_q   <= scp_pkg::RST_MEDIAN;
        end else if (factory_reset) begin
            laser_q <= scp_pkg::RST_LASER;
            task_q  <= scp_pkg::RST_TASK;
            scan_q  <= scp_pkg::RST_SCAN;
            xsup_q  <= scp_pkg::RST_XSUP;
            pause_q <= scp_pkg::RST_PAUSE;
            med_q   <= scp_pkg::RST_MEDIAN;
        end else if (restart) begin
            // unsaved changes are lost; scan number and laser keep running values
            task_q  <= sv_task_q;
            xsup_q  <= sv_xsup_q;
            pause_q <= sv_pause_q;
            med_q   <= sv_med_q;
        end else begin
            if (do_laser) begin
                laser_q <= flag_w0;
            end
            if (do_stask) begin
                task_q <= nib_w0;
            end
            if (do_scan) begin
                scan_q <= cmd_word0;
            end
            if (set_x) begin
                xsup_q <= flag_w2;
            end
            if (set_pause) begin
                pause_q <= nib_w2;
            end
            if (set_med) begin
                med_q <= flag_w2;
            end
        end
    end

    // saved copies, written when the persist flag is one with no restart, or on a factory reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sv_task_q  <= scp_pkg::RST_TASK;
            sv_xsup_q  <= scp_pkg::RST_XSUP;
            sv_pause_q <= scp_pkg::RST_PAUSE;
            sv_med_q   <= scp_pkg::RST_MEDIAN;
            save_q     <= 1'b0;
        end else if (factory_reset) begin
            sv_task_q  <= scp_pkg::RST_TASK;
            sv_xsup_q  <= scp_pkg::RST_XSUP;
            sv_pause_q <= scp_pkg::RST_PAUSE;
            sv_med_q   <= scp_pkg::RST_MEDIAN;
            save_q     <= 1'b1;
        end else begin
            save_q <= persist && !restart;
            if (persist && !restart) begin
                if (do_stask) begin
                    sv_task_q <= nib_w0;
                end
                if (set_x) begin
                    sv_xsup_q <= flag_w2;
                end
                if (set_pause) begin
                    sv_pause_q <= nib_w2;
                end
                if (set_med) begin
                    sv_med_q <= flag_w2;
                end
            end
        end
    end

    // z stream: filter only runs while measuring
    assign zf.in_valid = z_in_valid && !in_cmd;
    assign zf.in_z     = z_in;
    assign zf.enable   = med_q;

    scp_median3 #(.ZW(ZW)) u_median (
        .clk     (clk),
        .reset_n (reset_n),
        .zf      (zf.filter)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            zv_q <= 1'b0;
            zo_q <= '0;
        end else begin
            zv_q <= zf.out_valid;
            zo_q <= zf.out_z;
        end
    end

    assign rsp_valid          = rv_q;
    assign rsp_code           = rc_q;
    assign rsp_has_word       = rh_q;
    assign rsp_word           = rw_q;
    assign command_mode       = in_cmd;
    assign measuring          = !in_cmd;
    assign cascade_out_active = !in_cmd;
    assign laser_on_flag      = laser_q;
    assign active_task        = task_q;
    assign scan_number        = scan_q;
    assign x_suppress_flag    = xsup_q;
    assign x_output_enable    = !xsup_q;
    assign pause_steps        = pause_q;
    assign pause_cycles       = pcyc_q;
    assign median_enable_flag = med_q;
    assign saved_task         = sv_task_q;
    assign saved_x_suppress   = sv_xsup_q;
    assign saved_pause        = sv_pause_q;
    assign saved_median       = sv_med_q;
    assign save_strobe        = save_q;
    assign z_out_valid        = zv_q;
    assign z_out              = zo_q;
endmodule

// [design/scp_pkg.sv]
// constants for the sensor command-mode parser: command codes, answer codes,
// parameter identifiers, field positions, reset values and timing.
// assumes the command framing has already been stripped by the network side.
package scp_pkg;
    // command codes from the controller
    localparam logic [15:0] CMD_ENTER      = 16'h3132;
    localparam logic [15:0] CMD_EXIT       = 16'h3133;
    localparam logic [15:0] CMD_LASER      = 16'h0001;
    localparam logic [15:0] CMD_SET_TASK   = 16'h004B;
    localparam logic [15:0] CMD_GET_TASK   = 16'h0049;
    localparam logic [15:0] CMD_SET_SCAN   = 16'h0053;
    localparam logic [15:0] CMD_SET_USER   = 16'h0059;
    localparam logic [15:0] CMD_GET_USER   = 16'h005B;
    // answer codes
    localparam logic [15:0] RSP_ACK        = 16'h4141;
    localparam logic [15:0] RSP_NAK        = 16'h414E;
    localparam logic [15:0] RSP_TASK       = 16'h004A;
    localparam logic [15:0] RSP_USER       = 16'h005C;
    // user parameter identifiers
    localparam logic [15:0] PID_X_OUTPUT   = 16'h07D4;
    localparam logic [15:0] PID_PAUSE      = 16'h07D8;
    localparam logic [15:0] PID_MEDIAN     = 16'h07DB;
    // user-data word counts
    localparam logic [1:0]  NW_LASER       = 2'h1;
    localparam logic [1:0]  NW_SET_TASK    = 2'h2;
    localparam logic [1:0]  NW_GET_TASK    = 2'h0;
    localparam logic [1:0]  NW_SET_SCAN    = 2'h1;
    localparam logic [1:0]  NW_SET_USER    = 2'h3;
    localparam logic [1:0]  NW_GET_USER    = 2'h1;
    localparam logic [1:0]  NW_MODE        = 2'h0;
    // field positions
    localparam int          FLAG_BIT       = 0;
    localparam int          NIBBLE_MSB     = 3;
    // limits
    localparam logic [3:0]  PAUSE_MAX      = 4'h9;
    // reset / factory values
    localparam logic        RST_LASER      = 1'b1;
    localparam logic [3:0]  RST_TASK       = 4'h0;
    localparam logic [15:0] RST_SCAN       = 16'h0000;
    localparam logic        RST_XSUP       = 1'b0;
    localparam logic [3:0]  RST_PAUSE      = 4'h0;
    localparam logic        RST_MEDIAN     = 1'b0;
    // timing: pause step and clock period in ns
    localparam int          PAUSE_STEP_NS  = 100000;
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          PAUSE_STEP_CYC = PAUSE_STEP_NS / CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        MODE_MEASURE = 1'b0,
        MODE_COMMAND = 1'b1
    } scp_mode_t;
endpackage

// [design/scp_zf_if.sv]
// carrier for the z-coordinate stream between the parser and its median filter.
// assumes one z sample per valid cycle, no back-pressure.
`timescale 1ns/100ps
interface scp_zf_if #(parameter int ZW = 16);
    logic          in_valid;
    logic [ZW-1:0] in_z;
    logic          enable;
    logic          out_valid;
    logic [ZW-1:0] out_z;
    modport parser (output in_valid, output in_z, output enable,
                    input out_valid, input out_z);
    modport filter (input in_valid, input in_z, input enable,
                    output out_valid, output out_z);
endinterface

// [design/scp_median3.sv]
// three-tap median filter for z coordinates, bypassed when disabled.
// assumes samples of one profile arrive in order; history is kept across profiles.
`timescale 1ns/100ps
module scp_median3 #(
    parameter int ZW = 16
) (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  reset_n,
    // sample stream
    scp_zf_if.filter   zf
);
    logic [ZW-1:0] h1_q;
    logic [ZW-1:0] h2_q;
    logic [1:0]    fill_q;
    logic          ov_q;
    logic [ZW-1:0] oz_q;

    // median = max(min(a,b), min(max(a,b),c)) keeps steps, drops single spikes
    wire  [ZW-1:0] lo_ab  = (zf.in_z < h1_q) ? zf.in_z : h1_q;
    wire  [ZW-1:0] hi_ab  = (zf.in_z < h1_q) ? h1_q : zf.in_z;
    wire  [ZW-1:0] mid_c  = (hi_ab < h2_q) ? hi_ab : h2_q;
    wire  [ZW-1:0] med    = (lo_ab > mid_c) ? lo_ab : mid_c;
    wire           primed = (fill_q == 2'h2);
    wire  [ZW-1:0] sel_z  = (zf.enable && primed) ? med : zf.in_z;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            h1_q   <= '0;
            h2_q   <= '0;
            fill_q <= 2'h0;
            ov_q   <= 1'b0;
            oz_q   <= '0;
        end else begin
            ov_q <= zf.in_valid;
            if (zf.in_valid) begin
                h1_q <= zf.in_z;
                h2_q <= h1_q;
                oz_q <= sel_z;
                if (!primed) begin
                    fill_q <= fill_q + 2'h1;
                end
            end
        end
    end

    assign zf.out_valid = ov_q;
    assign zf.out_z     = oz_q;
endmodule

// [sim/scp_parser_properties.sv]
// checker for the command parser: answers, mode gating and setting updates.
// assumes it is bound to scp_parser and sees only its ports.
`timescale 1ns/100ps
module scp_parser_properties #(
    parameter int ZW = 16
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // command and answer
    input wire logic        cmd_valid,
    input wire logic [15:0] cmd_code,
    input wire logic [1:0]  cmd_words,
    input wire logic [15:0] cmd_word0,
    input wire logic [15:0] cmd_word1,
    input wire logic [15:0] cmd_word2,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_code,
    input wire logic [15:0] rsp_word,
    // events and settings
    input wire logic        restart,
    input wire logic        factory_reset,
    input wire logic        command_mode,
    input wire logic        measuring,
    input wire logic        cascade_out_active,
    input wire logic        laser_on_flag,
    input wire logic [3:0]  active_task,
    input wire logic [15:0] scan_number,
    input wire logic        x_suppress_flag,
    input wire logic [3:0]  pause_steps,
    input wire logic [3:0]  saved_task,
    input wire logic        save_strobe,
    // z stream
    input wire logic        z_in_valid,
    input wire logic        z_out_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic [3:0] word0_nib  = cmd_word0[3:0];
    wire logic       word0_flag = cmd_word0[0];
    // a command taken in command mode with no restart overriding it
    sequence s_cmd(logic [15:0] c, logic [1:0] n);
        cmd_valid && cmd_code == c && cmd_words == n && command_mode && !restart
            && !factory_reset;
    endsequence
    property p_answer;
        1'b1 |=> rsp_valid == $past(cmd_valid);
    endproperty
    a_answer: assert property (p_answer) else $error("answer timing");
    property p_exit_nak;
        cmd_valid && cmd_code == scp_pkg::CMD_EXIT && !command_mode
            |=> rsp_code == scp_pkg::RSP_NAK && !command_mode;
    endproperty
    a_exit_nak: assert property (p_exit_nak) else $error("exit not refused");
    property p_gate;
        cmd_valid && cmd_code == scp_pkg::CMD_ENTER && cmd_words == scp_pkg::NW_MODE
            |=> command_mode && !measuring && !cascade_out_active;
    endproperty
    a_gate: assert property (p_gate) else $error("gate after enter");
    property p_laser;
        s_cmd(scp_pkg::CMD_LASER, scp_pkg::NW_LASER)
            |=> rsp_code == scp_pkg::RSP_ACK && laser_on_flag == $past(word0_flag);
    endproperty
    a_laser: assert property (p_laser) else $error("laser flag");
    property p_scan;
        s_cmd(scp_pkg::CMD_SET_SCAN, scp_pkg::NW_SET_SCAN) |=> scan_number == $past(cmd_word0);
    endproperty
    a_scan: assert property (p_scan) else $error("scan number not loaded");
    property p_get_task;
        s_cmd(scp_pkg::CMD_GET_TASK, scp_pkg::NW_GET_TASK)
            |=> rsp_code == scp_pkg::RSP_TASK && rsp_word[3:0] == $past(active_task);
    endproperty
    a_get_task: assert property (p_get_task) else $error("task query");
    property p_persist_task;
        s_cmd(scp_pkg::CMD_SET_TASK, scp_pkg::NW_SET_TASK) ##0 cmd_word1[0]
            |=> active_task == $past(word0_nib) && saved_task == $past(word0_nib) && save_strobe;
    endproperty
    a_persist_task: assert property (p_persist_task) else $error("saved task not written");
    property p_xsup_hold;
        x_suppress_flag && !restart && !factory_reset
            && !(cmd_valid && cmd_code == scp_pkg::CMD_SET_USER
            && cmd_word1 == scp_pkg::PID_X_OUTPUT) |=> x_suppress_flag;
    endproperty
    a_xsup_hold: assert property (p_xsup_hold) else $error("x suppression cleared");
    property p_pause_nak;
        s_cmd(scp_pkg::CMD_SET_USER, scp_pkg::NW_SET_USER) ##0
            (cmd_word1 == scp_pkg::PID_PAUSE && cmd_word2[3:0] > scp_pkg::PAUSE_MAX)
            |=> rsp_code == scp_pkg::RSP_NAK && $stable(pause_steps);
    endproperty
    a_pause_nak: assert property (p_pause_nak) else $error("pause range");
    property p_z_latency;
        z_in_valid && !command_mode |-> ##2 z_out_valid;
    endproperty
    a_z_latency: assert property (p_z_latency) else $error("z latency");
endmodule

bind scp_parser scp_parser_properties #(.ZW(ZW)) u_scp_parser_properties (.*);

// [sim/scp_ctrl_model.sv]
// controller model: packs user words and sends one command per call.
// assumes the parser takes a command on the edge that sees cmd_valid high.
`timescale 1ns/100ps
module scp_ctrl_model (
    input wire logic    clk,
    output logic        cmd_valid,
    output logic [15:0] cmd_code,
    output logic [1:0]  cmd_words,
    output logic [15:0] cmd_word0,
    output logic [15:0] cmd_word1,
    output logic [15:0] cmd_word2
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 16'h0000;
        cmd_words = 2'h0;
        cmd_word0 = 16'h0000;
        cmd_word1 = 16'h0000;
        cmd_word2 = 16'h0000;
    end
    task automatic send(input logic [15:0] c, input logic [1:0] n, input logic [15:0] w0,
                        input logic [15:0] w1 = 16'h0000, input logic [15:0] w2 = 16'h0000);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_code  = c;
        cmd_words = n;
        cmd_word0 = w0;
        cmd_word1 = w1;
        cmd_word2 = w2;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        // released code and user words are scrambled so a stale value is never trusted; the word count is kept
        cmd_code  = ~c;
        cmd_word0 = ~w0;
        cmd_word1 = ~w1;
        cmd_word2 = ~w2;
    endtask
    task automatic set_task(input logic [3:0] t, input logic sf);
        send(scp_pkg::CMD_SET_TASK, scp_pkg::NW_SET_TASK, {12'h000, t}, {15'h0000, sf},
             16'h0000);
    endtask
    task automatic set_user(input logic sf, input logic [15:0] id, input logic [15:0] v);
        send(scp_pkg::CMD_SET_USER, scp_pkg::NW_SET_USER, {15'h0000, sf}, id, v);
    endtask
endmodule

// [sim/tb_scp_parser.sv]
// testbench for the command parser: mode control, settings, persistence, z stream.
// assumes the controller model drives the command port.
`timescale 1ns/100ps
module tb_scp_parser;
    logic clk, reset_n, restart, factory_reset, z_in_valid;
    logic [15:0] z_in;
    logic cmd_valid, rsp_valid, rsp_has_word, command_mode, measuring, cascade_out_active;
    logic laser_on_flag, x_suppress_flag, x_output_enable, median_enable_flag;
    logic saved_x_suppress, saved_median, save_strobe, z_out_valid;
    logic [15:0] cmd_code, cmd_word0, cmd_word1, cmd_word2, rsp_code, rsp_word;
    logic [15:0] scan_number, z_out;
    logic [1:0]  cmd_words;
    logic [3:0]  active_task, pause_steps, saved_task, saved_pause;
    logic [19:0] pause_cycles;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    scp_ctrl_model u_scp_ctrl_model (.*);
    scp_parser #(.ZW(16), .PAUSE_STEP_CYC(4)) u_scp_parser (.*);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // the run should need well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic check(input string name, input logic [19:0] got, input logic [19:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic expect_rsp(input logic [15:0] code);
        check("rsp_valid", 20'(rsp_valid), 20'h1);
        check("rsp_code", 20'(rsp_code), 20'(code));
    endtask
    task automatic pulse(input logic fr);
        @(posedge clk);
        #1;
        factory_reset = fr;
        restart = !fr;
        @(posedge clk);
        #1;
        factory_reset = 1'b0;
        restart = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic t_modes;
        u_scp_ctrl_model.send(scp_pkg::CMD_EXIT, 2'h0, 16'h0000);
        expect_rsp(scp_pkg::RSP_NAK);
        u_scp_ctrl_model.send(scp_pkg::CMD_LASER, 2'h1, 16'h0000);
        expect_rsp(scp_pkg::RSP_NAK);
        u_scp_ctrl_model.send(scp_pkg::CMD_ENTER, 2'h0, 16'h0000);
        expect_rsp(scp_pkg::RSP_ACK);
        check("command_mode", 20'(command_mode), 20'h1);
        check("measuring", 20'(measuring), 20'h0);
        check("cascade", 20'(cascade_out_active), 20'h0);
        $display("test modes done");
    endtask
    task automatic t_laser;
        u_scp_ctrl_model.send(scp_pkg::CMD_LASER, 2'h1, 16'hFFFE);
        check("laser off", 20'(laser_on_flag), 20'h0);
        u_scp_ctrl_model.send(scp_pkg::CMD_LASER, 2'h1, 16'h0001);
        check("laser on", 20'(laser_on_flag), 20'h1);
        u_scp_ctrl_model.send(scp_pkg::CMD_LASER, 2'h2, 16'h0000);
        expect_rsp(scp_pkg::RSP_NAK);
        check("laser kept", 20'(laser_on_flag), 20'h1);
        $display("test laser done");
    endtask
    task automatic t_task;
        u_scp_ctrl_model.set_task(4'hF, 1'b0);
        check("task", 20'(active_task), 20'hF);
        check("saved temp", 20'(saved_task), 20'h0);
        u_scp_ctrl_model.send(scp_pkg::CMD_GET_TASK, 2'h0, 16'h0000);
        expect_rsp(scp_pkg::RSP_TASK);
        check("task word", 20'(rsp_word[3:0]), 20'hF);
        check("task has word", 20'(rsp_has_word), 20'h1);
        u_scp_ctrl_model.set_task(4'h9, 1'b1);
        check("save strobe", 20'(save_strobe), 20'h1);
        u_scp_ctrl_model.set_task(4'h3, 1'b0);
        pulse(1'b0);
        check("task restart", 20'(active_task), 20'h9);
        $display("test task done");
    endtask
    task automatic t_scan;
        // master side of a cascade alignment: command mode, then the scan number
        u_scp_ctrl_model.send(scp_pkg::CMD_SET_SCAN, 2'h1, 16'h8001);
        expect_rsp(scp_pkg::RSP_ACK);
        check("scan", 20'(scan_number), 20'h8001);
        $display("test scan done");
    endtask
    task automatic t_user;
        u_scp_ctrl_model.set_user(1'b1, scp_pkg::PID_X_OUTPUT, 16'h0001);
        expect_rsp(scp_pkg::RSP_ACK);
        u_scp_ctrl_model.set_user(1'b0, scp_pkg::PID_PAUSE, 16'h0009);
        @(posedge clk);
        #1;
        check("x out", 20'(x_output_enable), 20'h0);
        check("pause cycles", pause_cycles, 20'h28);
        check("saved pause", 20'(saved_pause), 20'h0);
        u_scp_ctrl_model.set_user(1'b0, scp_pkg::PID_PAUSE, 16'h000A);
        expect_rsp(scp_pkg::RSP_NAK);
        check("pause kept", 20'(pause_steps), 20'h9);
        u_scp_ctrl_model.set_user(1'b0, 16'h07D5, 16'h0000);
        expect_rsp(scp_pkg::RSP_NAK);
        pulse(1'b0);
        check("xsup restart", 20'(x_suppress_flag), 20'h1);
        check("pause restart", 20'(pause_steps), 20'h0);
        u_scp_ctrl_model.set_user(1'b1, scp_pkg::PID_MEDIAN, 16'h0001);
        u_scp_ctrl_model.set_task(4'h4, 1'b0);
        check("median all tasks", 20'(median_enable_flag), 20'h1);
        u_scp_ctrl_model.send(scp_pkg::CMD_GET_USER, 2'h1, scp_pkg::PID_MEDIAN);
        expect_rsp(scp_pkg::RSP_USER);
        check("user word", 20'(rsp_word), 20'h1);
        check("user has word", 20'(rsp_has_word), 20'h1);
        u_scp_ctrl_model.send(scp_pkg::CMD_EXIT, 2'h0, 16'h0000);
        expect_rsp(scp_pkg::RSP_ACK);
        check("measuring", 20'(measuring), 20'h1);
        $display("test user done");
    endtask
    task automatic z_send(input logic [15:0] v, input logic [15:0] exp);
        @(posedge clk);
        #1;
        z_in_valid = 1'b1;
        z_in = v;
        @(posedge clk);
        #1;
        z_in_valid = 1'b0;
        z_in = ~v;
        @(posedge clk);
        #1;
        check("z valid", 20'(z_out_valid), 20'h1);
        check("z out", 20'(z_out), 20'(exp));
    endtask
    task automatic t_z;
        z_send(16'h0010, 16'h0010);
        z_send(16'h0050, 16'h0050);
        z_send(16'h0020, 16'h0020);
        z_send(16'h0030, 16'h0030);
        z_send(16'h0100, 16'h0030);
        $display("test z done");
    endtask
    task automatic t_factory;
        check("saved median", 20'(saved_median), 20'h1);
        pulse(1'b1);
        check("xsup factory", 20'(x_suppress_flag), 20'h0);
        check("saved xsup", 20'(saved_x_suppress), 20'h0);
        check("median factory", 20'(saved_median), 20'h0);
        $display("test factory done");
    endtask
    initial begin
        reset_n = 1'b0;
        restart = 1'b0;
        factory_reset = 1'b0;
        z_in_valid = 1'b0;
        z_in = 16'h0000;
        repeat (4) @(posedge clk);
        #1;
        reset_n = 1'b1;
        t_modes();
        t_laser();
        t_task();
        t_scan();
        t_user();
        t_z();
        t_factory();
        end_sim();
    end
endmodule
